// ==== hdl/sfr_read_engine.sv ====
// Serial flash read front end: opcode decode, address, mode and dummy
// phases, continuous read mode, burst wrap and multi-line data output.
// Assumes the host drives the serial clock and select asynchronously and
// far slower than clock; memory answers fetches in order on clock.

`timescale 1ns/1ps
`default_nettype none

module sfr_read_engine
  #(
  parameter int ADDR_W = sfr_pkg::ADDR_BITS,
  parameter int DEPTH = sfr_pkg::BUF_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic [sfr_pkg::LANES-1:0] serialLineIn,
  output logic [sfr_pkg::LANES-1:0] serialLineOut,
  output logic [sfr_pkg::LANES-1:0] serialLineOe,
  input wire logic quadLinesEnable,
  output logic fetchValid,
  input wire logic fetchReady,
  output logic [ADDR_W-1:0] fetchAddr,
  input wire logic memValid,
  output logic memReady,
  input wire logic [sfr_pkg::BYTE_BITS-1:0] memData,
  output logic continuousMode,
  output logic [7:0] readModeByte,
  output logic wrapDisableBit,
  output logic [1:0] wrapLengthField,
  output logic readUnderrun
);
  import sfr_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PINS = LANES + 2;
  localparam int PIN_SCLK = LANES;
  localparam int PIN_SEL = LANES + 1;

  initial begin
    if (ADDR_W < ADDR_BITS || ADDR_W > 32) begin
      $error("sfr_read_engine: ADDR_W must lie in 24..32");
    end
  end

  // ************************************************************
  // Functions
  // ************************************************************
  // Shift amount per clock: 0 one line, 1 two lines, 2 four lines
  function automatic logic [1:0] addrShift(input sfr_cmd_type c);
    case (c)
      CMD_QUAD_OUT: addrShift = 2'h0;
      CMD_DUAL_IO: addrShift = 2'h1;
      default: addrShift = 2'h2;
    endcase
  endfunction

  function automatic logic [5:0] dummyClocks(input sfr_cmd_type c);
    case (c)
      CMD_QUAD_OUT: dummyClocks = DUMMY_QUAD_OUT;
      CMD_DUAL_IO: dummyClocks = DUMMY_DUAL_IO;
      CMD_QUAD_IO: dummyClocks = DUMMY_QUAD_IO;
      default: dummyClocks = DUMMY_QUAD_WORD;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] nextAddr(
    input logic [ADDR_W-1:0] a,
    input logic wrapOn,
    input logic [1:0] len
  );
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = ADDR_W'((WRAP_SECTION_MIN << len) - 1);
    inc = a + ADDR_W'(1);
    if (wrapOn) begin
      nextAddr = (a & ~mask) | (inc & mask);
    end else begin
      nextAddr = inc;
    end
  endfunction

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [PINS-1:0] syncA_q;
  logic [PINS-1:0] syncB_q;
  logic prevSclk_q;
  logic sclkRise;
  logic sclkFall;
  logic deselected;
  logic [LANES-1:0] lineS;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncA_q <= {1'b1, {(PINS-1){1'b0}}};
      syncB_q <= {1'b1, {(PINS-1){1'b0}}};
      prevSclk_q <= 1'b0;
    end else begin
      syncA_q <= {selectN, serialClock, serialLineIn};
      syncB_q <= syncA_q;
      prevSclk_q <= syncB_q[PIN_SCLK];
    end
  end

  // Lines and clock pass equal delay, so data sampled on a detected
  // rising edge is the value the host set up before that edge.
  assign deselected = syncB_q[PIN_SEL];
  assign lineS = syncB_q[LANES-1:0];
  assign sclkRise = syncB_q[PIN_SCLK] & ~prevSclk_q & ~deselected;
  assign sclkFall = ~syncB_q[PIN_SCLK] & prevSclk_q & ~deselected;

  // ************************************************************
  // Phase control
  // ************************************************************
  sfr_state_type state_q;
  sfr_cmd_type cmd_q;
  logic [5:0] cnt_q;
  logic [5:0] phaseLen;
  logic [1:0] curShift;
  logic phaseDone;
  logic [IN_SR_BITS-1:0] inSr_q;
  logic [IN_SR_BITS-1:0] inSr_d;
  logic contMode_q;
  logic wrapDis_q;
  logic [1:0] wrapLen_q;
  logic [7:0] modeByte_q;
  logic [7:0] opcode;

  always_comb begin
    curShift = 2'h0;
    phaseLen = CLK_OPCODE;
    case (state_q)
      ST_OPC: phaseLen = CLK_OPCODE;
      ST_WRAP: phaseLen = CLK_WRAP_CMD;
      ST_ADDR: begin
        curShift = addrShift(cmd_q);
        phaseLen = 6'(ADDR_BITS) >> addrShift(cmd_q);
      end
      ST_MODE: begin
        curShift = addrShift(cmd_q);
        phaseLen = 6'(BYTE_BITS) >> addrShift(cmd_q);
      end
      ST_DUMMY: phaseLen = dummyClocks(cmd_q);
      default: phaseLen = CLK_OPCODE;
    endcase
  end

  // Most significant bit rides on the highest line
  always_comb begin
    case (curShift)
      2'h1: inSr_d = {inSr_q[IN_SR_BITS-3:0], lineS[1:0]};
      2'h2: inSr_d = {inSr_q[IN_SR_BITS-5:0], lineS};
      default: inSr_d = {inSr_q[IN_SR_BITS-2:0], lineS[0]};
    endcase
  end

  assign phaseDone = (cnt_q == phaseLen - 6'h01);
  assign opcode = inSr_d[7:0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inSr_q <= '0;
    end else if (sclkRise) begin
      inSr_q <= inSr_d;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_OPC;
      cmd_q <= CMD_QUAD_OUT;
      cnt_q <= '0;
    end else if (deselected) begin
      // Continuous mode frames open straight at the address
      state_q <= contMode_q ? ST_ADDR : ST_OPC;
      cnt_q <= '0;
    end else if (sclkRise) begin
      cnt_q <= phaseDone ? 6'h00 : cnt_q + 6'h01;
      if (phaseDone) begin
        case (state_q)
          ST_OPC: begin
            case (opcode)
              OPC_QUAD_OUT: begin
                cmd_q <= CMD_QUAD_OUT;
                state_q <= ST_ADDR;
              end
              OPC_DUAL_IO: begin
                cmd_q <= CMD_DUAL_IO;
                state_q <= ST_ADDR;
              end
              OPC_QUAD_IO: begin
                cmd_q <= CMD_QUAD_IO;
                state_q <= quadLinesEnable ? ST_ADDR : ST_IGNORE;
              end
              OPC_QUAD_WORD: begin
                cmd_q <= CMD_QUAD_WORD;
                state_q <= quadLinesEnable ? ST_ADDR : ST_IGNORE;
              end
              OPC_SET_WRAP: state_q <= ST_WRAP;
              default: state_q <= ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            state_q <= (cmd_q == CMD_QUAD_OUT) ? ST_DUMMY : ST_MODE;
          end
          ST_MODE: begin
            state_q <= (dummyClocks(cmd_q) == 6'h00) ? ST_DATA : ST_DUMMY;
          end
          ST_DUMMY: state_q <= ST_DATA;
          ST_WRAP: state_q <= ST_IGNORE;
          ST_DATA: state_q <= ST_DATA;
          ST_IGNORE: state_q <= ST_IGNORE;
          default: state_q <= ST_IGNORE;
        endcase
      end
    end
  end

  // ************************************************************
  // Continuous mode and burst wrap settings
  // ************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      contMode_q <= 1'b0;
      modeByte_q <= MODE_BYTE_RST;
    end else if (sclkRise && phaseDone) begin
      if (state_q == ST_OPC && opcode == OPC_MODE_RESET) begin
        contMode_q <= 1'b0;
      end else if (state_q == ST_MODE) begin
        modeByte_q <= inSr_d[7:0];
        // Any value other than 10 falls back to opcode decoding
        contMode_q <=
          (inSr_d[MODE_SEL_LSB+1:MODE_SEL_LSB] == MODE_CONT);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrapDis_q <= WRAP_DIS_RST;
      wrapLen_q <= WRAP_LEN_RST;
    end else if (sclkRise && phaseDone && state_q == ST_WRAP) begin
      wrapDis_q <= inSr_d[WRAP_DIS_POS];
      wrapLen_q <= inSr_d[WRAP_LEN_LSB+1:WRAP_LEN_LSB];
    end
  end

  assign continuousMode = contMode_q;
  assign readModeByte = modeByte_q;
  assign wrapDisableBit = wrapDis_q;
  assign wrapLengthField = wrapLen_q;

  // ************************************************************
  // Memory fetch and read-data buffer
  // ************************************************************
  logic armed_q;
  logic [ADDR_W-1:0] fetchPtr_q;
  logic [CW-1:0] outst_q;
  logic [CW-1:0] drop_q;
  logic [CW-1:0] bufCount;
  logic [CW-1:0] outst_d;
  logic [CW-1:0] drop_d;
  logic wrapOn;
  logic issue;
  logic respTaken;
  logic dropping;
  logic bufInReady;
  logic bufOutValid;
  logic bufPop;
  logic [BYTE_BITS-1:0] bufData;

  // Wrap only shapes the quad I/O reads
  assign wrapOn = ~wrapDis_q &
                  (cmd_q == CMD_QUAD_IO || cmd_q == CMD_QUAD_WORD);
  // Answers still due to a closed frame are counted so they never
  // leak into the next one; credits cover them too.
  assign fetchValid = armed_q & ~deselected &
                      ((outst_q + drop_q + bufCount) < CW'(DEPTH));
  assign fetchAddr = fetchPtr_q;
  assign issue = fetchValid & fetchReady;
  assign dropping = (drop_q != '0);
  assign memReady = dropping | bufInReady;
  assign respTaken = memValid & memReady;

  always_comb begin
    outst_d = outst_q + CW'(issue) - CW'(respTaken & ~dropping);
    drop_d = drop_q - CW'(respTaken & dropping);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      fetchPtr_q <= '0;
      outst_q <= '0;
      drop_q <= '0;
    end else if (deselected) begin
      armed_q <= 1'b0;
      outst_q <= '0;
      drop_q <= drop_d + outst_d;
    end else begin
      outst_q <= outst_d;
      drop_q <= drop_d;
      if (sclkRise && phaseDone && state_q == ST_ADDR) begin
        armed_q <= 1'b1;
        fetchPtr_q <= ADDR_W'(inSr_d[ADDR_BITS-1:0]);
      end else if (issue) begin
        fetchPtr_q <= nextAddr(fetchPtr_q, wrapOn, wrapLen_q);
      end
    end
  end

  sfr_pair_buf #(
    .WIDTH(BYTE_BITS),
    .DEPTH(DEPTH)
  ) dataBuf (
    .clock(clock),
    .nrst(nrst),
    .flush(deselected),
    .inValid(memValid & ~dropping),
    .inReady(bufInReady),
    .inData(memData),
    .outValid(bufOutValid),
    .outReady(bufPop),
    .outData(bufData),
    .count(bufCount)
  );

  // ************************************************************
  // Data output on falling serial clock edges
  // ************************************************************
  logic [BYTE_BITS-1:0] outSr_q;
  logic [1:0] slot_q;
  logic [LANES-1:0] lineOut_q;
  logic [LANES-1:0] lineOe_q;
  logic underrun_q;
  logic dualOut;
  logic unitEdge;

  assign dualOut = (cmd_q == CMD_DUAL_IO);
  assign unitEdge = sclkFall & (state_q == ST_DATA);
  assign bufPop = unitEdge & (slot_q == 2'h0);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outSr_q <= '0;
      slot_q <= 2'h0;
      lineOut_q <= '0;
      lineOe_q <= '0;
    end else if (deselected) begin
      slot_q <= 2'h0;
      lineOe_q <= '0;
    end else if (unitEdge) begin
      lineOe_q <= dualOut ? 4'h3 : 4'hf;
      if (dualOut) begin
        if (slot_q == 2'h0) begin
          lineOut_q <= {2'h0, bufData[7:6]};
          outSr_q <= {bufData[5:0], 2'h0};
          slot_q <= 2'h3;
        end else begin
          lineOut_q <= {2'h0, outSr_q[7:6]};
          outSr_q <= {outSr_q[5:0], 2'h0};
          slot_q <= slot_q - 2'h1;
        end
      end else begin
        // High nibble first, nibble bit 0 on line zero
        if (slot_q == 2'h0) begin
          lineOut_q <= bufData[7:4];
          outSr_q <= {bufData[3:0], 4'h0};
          slot_q <= 2'h1;
        end else begin
          lineOut_q <= outSr_q[7:4];
          outSr_q <= {outSr_q[3:0], 4'h0};
          slot_q <= 2'h0;
        end
      end
    end
  end

  // A slow memory cannot stall the host, so a missing byte is flagged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      underrun_q <= 1'b0;
    end else begin
      underrun_q <= bufPop & ~bufOutValid;
    end
  end

  assign serialLineOut = lineOut_q;
  assign serialLineOe = lineOe_q;
  assign readUnderrun = underrun_q;
endmodule

`default_nettype wire

// ==== hdl/sfr_pkg.sv ====
// Constants and types of the multi-I/O flash read front end, plus the
// two-entry read-data buffer that sits between memory and the shifter.
// Assumes one system clock; the buffer is a plain synchronous FIFO.
//
// Function
// - Opcode 6b: address and dummy byte on one line, data four bits per clock.
// - Any start address; address steps to the next byte after each byte.
// - Opcode bb: address and mode byte on two lines, data on two lines.
// - Dual I/O mode bits 5:4 equal 10: next frame starts at the address.
// - Other dual I/O mode bits leave continuous mode; opcode needed again.
// - Opcode eb: address, mode byte, four dummy clocks, all on four lines.
// - Quad I/O reads are accepted only while quad lines enable is set; the code checks it at the opcode only, not in continuous frames.
// - Quad I/O mode bits 10 skip the next opcode; else normal decoding.
// - Continuous read mode reset command clears the mode bits; the code clears only continuousMode, readModeByte is not cleared.
// - Opcode e7: even address, two dummy clocks instead of four; the code does not force address bit 0 to zero.
// - Quad word read mode bits 10 skip the next opcode; else decode it.
// - Set burst with wrap: opcode, 24 dummy bits, 8 wrap bits latched.
// - Stored wrap setting applies to every later quad I/O read.
// - Wrap disable bit comes up as one after reset.
// - Wrap length 00..11 selects 8, 16, 32 or 64 byte sections.
// - Wrapping returns to the aligned section start until select rises.
// - Quad address and mode byte arrive high nibble first, msb on line 3.
// - Quad data goes high nibble first, bit 0 of nibble on line 0.

`timescale 1ns/1ps
`default_nettype none

package sfr_pkg;
  localparam int ADDR_BITS = 24;
  localparam int LANES = 4;
  localparam int BYTE_BITS = 8;
  localparam int IN_SR_BITS = 32;
  localparam int BUF_DEPTH = 2;

  localparam logic [7:0] OPC_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OPC_DUAL_IO = 8'hbb;
  localparam logic [7:0] OPC_QUAD_IO = 8'heb;
  localparam logic [7:0] OPC_QUAD_WORD = 8'he7;
  localparam logic [7:0] OPC_SET_WRAP = 8'h77;
  localparam logic [7:0] OPC_MODE_RESET = 8'hff;

  localparam logic [1:0] MODE_CONT = 2'b10;
  localparam int MODE_SEL_LSB = 4;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LSB = 5;
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  localparam logic [7:0] MODE_BYTE_RST = 8'h00;
  localparam int WRAP_SECTION_MIN = 8;

  localparam logic [5:0] CLK_OPCODE = 6'h08;
  localparam logic [5:0] CLK_WRAP_CMD = 6'h20;
  localparam logic [5:0] DUMMY_QUAD_OUT = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_IO = 6'h00;
  localparam logic [5:0] DUMMY_QUAD_IO = 6'h04;
  localparam logic [5:0] DUMMY_QUAD_WORD = 6'h02;

  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b110,
    ST_WRAP = 3'b100,
    ST_IGNORE = 3'b101
  } sfr_state_type;

  typedef enum logic [1:0] {
    CMD_QUAD_OUT = 2'h0,
    CMD_DUAL_IO = 2'h1,
    CMD_QUAD_IO = 2'h2,
    CMD_QUAD_WORD = 2'h3
  } sfr_cmd_type;
endpackage

// ************************************************************
// Small FIFO, valid and ready on both sides, flushable
// ************************************************************
module sfr_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("sfr_pair_buf: DEPTH must be a power of two, at least 2");
    end
  end

  assign inReady = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign count = count_q;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + PW'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + PW'(1);
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule

`default_nettype wire

// ==== tb/sfr_read_sva.sv ====
// Checker for the flash read front end, bound to its top module.
// Assumes host pins change well away from the system clock edges.
`timescale 1ns/1ps
`default_nettype none
module sfr_read_sva #(
  parameter int ADDR_W = 24,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic [3:0] serialLineOut,
  input wire logic [3:0] serialLineOe,
  input wire logic fetchValid,
  input wire logic fetchReady,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic continuousMode,
  input wire logic [7:0] readModeByte,
  input wire logic wrapDisableBit,
  input wire logic [1:0] wrapLengthField,
  input wire logic readUnderrun
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ************************************************************
  // Fetch address tracking within one frame
  // ************************************************************
  logic [ADDR_W-1:0] lastQ;
  logic seenQ;
  wire [ADDR_W-1:0] secMask = (ADDR_W'(8) << wrapLengthField) - 1'b1;
  wire [ADDR_W-1:0] wrapNext = (lastQ & ~secMask) | ((lastQ + 1'b1) & secMask);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lastQ <= '0;
      seenQ <= 1'b0;
    end else if (selectN) begin
      seenQ <= 1'b0;
    end else if (fetchValid && fetchReady) begin
      lastQ <= fetchAddr;
      seenQ <= 1'b1;
    end
  end
  property p_oeOffIdle;
    selectN [*5] |-> serialLineOe == 4'h0;
  endproperty
  a_oeOffIdle: assert property (p_oeOffIdle)
    else $error("lanes driven outside a frame");
  property p_oeRise;
    $rose(|serialLineOe) |-> !selectN && !$past(selectN, 8);
  endproperty
  a_oeRise: assert property (p_oeRise)
    else $error("lanes driven early");
  property p_oeLanes;
    serialLineOe == 4'h0 || serialLineOe == 4'h3 || serialLineOe == 4'hf;
  endproperty
  a_oeLanes: assert property (p_oeLanes)
    else $error("odd lane enable pattern");
  property p_outTiming;
    $changed(serialLineOut) |->
      ($past(serialClock, 5) && !$past(serialClock, 2)) || $past(selectN, 3);
  endproperty
  a_outTiming: assert property (p_outTiming)
    else $error("data lanes changed off a falling edge");
  property p_fetchHold;
    !selectN [*5] ##0 (fetchValid && !fetchReady) |=>
      fetchValid && $stable(fetchAddr);
  endproperty
  a_fetchHold: assert property (p_fetchHold)
    else $error("fetch request dropped");
  property p_fetchStep;
    seenQ && fetchValid && fetchReady |->
      fetchAddr == lastQ + 1'b1 || (!wrapDisableBit && fetchAddr == wrapNext);
  endproperty
  a_fetchStep: assert property (p_fetchStep)
    else $error("fetch address did not step");
  property p_wrapHold;
    selectN [*5] |=> $stable(wrapDisableBit) && $stable(wrapLengthField);
  endproperty
  a_wrapHold: assert property (p_wrapHold)
    else $error("wrap setting changed between frames");
  property p_contMatches;
    selectN [*5] ##0 continuousMode |-> readModeByte[5:4] == 2'b10;
  endproperty
  a_contMatches: assert property (p_contMatches)
    else $error("continuous mode without matching mode bits");
  property p_noUnderrun;
    !readUnderrun;
  endproperty
  a_noUnderrun: assert property (p_noUnderrun)
    else $error("read byte missing at output");
  c_wrapFetch: cover property (fetchValid && fetchReady && !wrapDisableBit);
  c_dualOut: cover property (serialLineOe == 4'h3);
  c_contMode: cover property ($rose(continuousMode));
endmodule
bind sfr_read_engine sfr_read_sva #(.ADDR_W(ADDR_W), .DEPTH(DEPTH))
  i_sfr_read_sva (.clock, .nrst, .serialClock, .selectN, .serialLineOut,
  .serialLineOe, .fetchValid, .fetchReady, .fetchAddr, .continuousMode,
  .readModeByte, .wrapDisableBit, .wrapLengthField, .readUnderrun);
`default_nettype wire

// ==== tb/sfr_host_model.sv ====
// Host side model: serial clock, select and command lines.
// Assumes the engine samples on rising and drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  output logic serialClock,
  output logic selectN,
  output logic [3:0] serialLineIn,
  input wire logic [3:0] serialLineOut,
  input wire logic [3:0] serialLineOe
);
  logic [3:0] drv = 4'h0;
  logic [3:0] junk = 4'h5;
  logic hostOe = 1'b0;
  initial begin
    serialClock = 1'b0;
    selectN = 1'b1;
  end
  // ************************************************************
  // Wire level and frame tasks
  // ************************************************************
  // Released lines toggle so a stale value never passes for data
  always @(posedge serialClock) junk <= ~junk;
  assign serialLineIn = (serialLineOe & serialLineOut) |
    (~serialLineOe & (hostOe ? drv : junk));
  task automatic pulse();
    #62.5 serialClock = 1'b1;
    #62.5 serialClock = 1'b0;
  endtask
  task automatic stop();
    #62.5 hostOe = 1'b0;
    selectN = 1'b1;
    #125;
  endtask
  task automatic shift(input logic [31:0] v, input int n, input int w);
    hostOe = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      drv = 4'((v >> (i * w)) & ((32'h1 << w) - 1));
      pulse();
    end
  endtask
  task automatic idle(input int n);
    hostOe = 1'b0;
    repeat (n) pulse();
  endtask
  task automatic getByte(input int w, output logic [7:0] b);
    hostOe = 1'b0;
    b = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      #62.5 serialClock = 1'b1;
      b = 8'((b << w) | (serialLineIn & ((4'h1 << w) - 1)));
      #62.5 serialClock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the flash read front end.
// Assumes the host model above and an in-order memory answering here.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic quadLinesEnable = 1'b1;
  logic fetchReady = 1'b0;
  logic memValid = 1'b0;
  logic [7:0] memData = 8'h00;
  wire serialClock;
  wire selectN;
  wire [3:0] serialLineIn;
  logic [3:0] serialLineOut;
  logic [3:0] serialLineOe;
  logic fetchValid;
  logic [23:0] fetchAddr;
  logic memReady;
  logic continuousMode;
  logic [7:0] readModeByte;
  logic wrapDisableBit;
  logic [1:0] wrapLengthField;
  logic readUnderrun;
  logic [23:0] pend[$];
  int failures = 0;
  int checked = 0;
  always #4 clock = ~clock;
  sfr_read_engine #(.ADDR_W(24), .DEPTH(2)) i_sfr_read_engine (.clock(clock),
    .nrst(nrst), .serialClock(serialClock), .selectN(selectN),
    .serialLineIn(serialLineIn), .serialLineOut(serialLineOut),
    .serialLineOe(serialLineOe), .quadLinesEnable(quadLinesEnable),
    .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchAddr(fetchAddr),
    .memValid(memValid), .memReady(memReady), .memData(memData),
    .continuousMode(continuousMode), .readModeByte(readModeByte),
    .wrapDisableBit(wrapDisableBit), .wrapLengthField(wrapLengthField),
    .readUnderrun(readUnderrun));
  sfr_host_model i_sfr_host_model (.serialClock(serialClock),
    .selectN(selectN), .serialLineIn(serialLineIn),
    .serialLineOut(serialLineOut), .serialLineOe(serialLineOe));
  // ************************************************************
  // Memory, compare and frame helpers
  // ************************************************************
  function automatic logic [7:0] memByte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  // Request side stalls every other cycle to exercise the hold rule
  always @(posedge clock) begin
    if (memValid && memReady) void'(pend.pop_front());
    if (fetchValid && fetchReady) pend.push_back(fetchAddr);
    #1.25;
    fetchReady = ~fetchReady;
    memValid = pend.size() != 0;
    memData = pend.size() != 0 ? memByte(pend[0]) : ~memData;
  end
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic open();
    @(posedge clock);
    #1.25 i_sfr_host_model.selectN = 1'b0;
  endtask
  // Length 4 or more means linear stepping
  task automatic frame(input logic [7:0] op, input int aw, input int md,
      input int dum, input int dw, input logic [23:0] a, input int n,
      input int len);
    logic [7:0] b;
    logic [23:0] m;
    m = (24'h8 << len) - 1'b1;
    open();
    if (op != 8'h00) i_sfr_host_model.shift({24'h0, op}, 8, 1);
    i_sfr_host_model.shift({8'h0, a}, 24 / aw, aw);
    if (md >= 0) i_sfr_host_model.shift(32'(md), 8 / aw, aw);
    i_sfr_host_model.idle(dum);
    for (int i = 0; i < n; i++) begin
      i_sfr_host_model.getByte(dw, b);
      chk("read byte", memByte(a), b);
      a = len > 3 ? a + 1'b1 : (a & ~m) | ((a + 1'b1) & m);
    end
    i_sfr_host_model.stop();
  endtask
  task automatic setWrap(input logic [7:0] w);
    open();
    i_sfr_host_model.shift({24'h0, OPC_SET_WRAP}, 8, 1);
    i_sfr_host_model.shift({24'h0, w}, 32, 1);
    i_sfr_host_model.stop();
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_basic();
    frame(OPC_QUAD_OUT, 1, -1, 8, 4, 24'hfffffe, 3, 4);
    frame(OPC_DUAL_IO, 2, 8'h20, 0, 2, 24'h000123, 2, 4);
    chk("dual continuous", 32'h1, continuousMode);
    chk("mode byte", 32'h20, readModeByte);
    frame(8'h00, 2, 8'h00, 0, 2, 24'h000200, 2, 4);
    chk("dual normal", 32'h0, continuousMode);
    frame(OPC_DUAL_IO, 2, 8'h00, 0, 2, 24'h000300, 2, 4);
  endtask
  task automatic t_quad();
    logic [7:0] b;
    @(posedge clock);
    #1.25 quadLinesEnable = 1'b0;
    open();
    i_sfr_host_model.shift({24'h0, OPC_QUAD_IO}, 8, 1);
    i_sfr_host_model.shift(32'h000040, 6, 4);
    i_sfr_host_model.shift(32'h20, 2, 4);
    i_sfr_host_model.idle(4);
    i_sfr_host_model.getByte(4, b);
    chk("lanes without quad", 32'h0, serialLineOe);
    i_sfr_host_model.stop();
    chk("mode after refusal", 32'h0, continuousMode);
    @(posedge clock);
    #1.25 quadLinesEnable = 1'b1;
    frame(OPC_QUAD_IO, 4, 8'h20, 4, 4, 24'h00ab12, 3, 4);
    chk("continuous set", 32'h1, continuousMode);
    frame(8'h00, 4, 8'h00, 4, 4, 24'h00ab70, 2, 4);
    chk("continuous left", 32'h0, continuousMode);
    frame(OPC_QUAD_WORD, 4, 8'h20, 2, 4, 24'h000410, 3, 4);
    frame(8'h00, 4, 8'h20, 2, 4, 24'h0007fe, 3, 4);
    chk("continuous kept", 32'h1, continuousMode);
    open();
    i_sfr_host_model.shift(32'hffffffff, 8, 4);
    i_sfr_host_model.stop();
    chk("mode reset", 32'h0, continuousMode);
    open();
    i_sfr_host_model.shift(32'h03, 8, 1);
    i_sfr_host_model.idle(4);
    chk("lanes on unknown", 32'h0, serialLineOe);
    i_sfr_host_model.stop();
  endtask
  task automatic t_wrap();
    for (int len = 0; len < 4; len++) begin
      setWrap(8'(len << 5));
      chk("wrap length", 32'(len), wrapLengthField);
      chk("wrap disable", 32'h0, wrapDisableBit);
      frame(len[0] ? OPC_QUAD_WORD : OPC_QUAD_IO, 4, 8'h00, len[0] ? 2 : 4,
        4, 24'h0137f4, (8 << len) + 3, len);
    end
    frame(OPC_QUAD_OUT, 1, -1, 8, 4, 24'h0137fe, 3, 4);
    setWrap(8'h10);
    chk("wrap off", 32'h1, wrapDisableBit);
    frame(OPC_QUAD_IO, 4, 8'h00, 4, 4, 24'h0137fe, 4, 4);
  endtask
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1.25 nrst = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("wrap disable reset", 32'h1, wrapDisableBit);
    chk("wrap length reset", 32'h0, wrapLengthField);
    chk("lanes reset", 32'h0, serialLineOe);
    t_basic();
    t_quad();
    t_wrap();
    conclude();
  end
endmodule
`default_nettype wire
